// file: sha_host.sv
// Host model: SPI master in mode 0 that sends whole frames to sha_top.
// Assumes frame() is called on a falling sys_clk edge; SCK rests low between frames.
`timescale 1ns/1ps
`default_nettype none
module sha_host (
  output logic sck,
  output logic cs_n,
  output logic mosi,
  input wire logic miso,
  input wire logic miso_oe_n
);
  logic [15:0] rx [0:7]; // Words shifted in, first word at index 0
  logic miso_wire; // Level the host really sees
  // A released line shows the opposite level, so stale data cannot pass
  assign miso_wire = miso_oe_n ? ~miso : miso;
  // Idle levels at time zero
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // One bit: data set after a fall, sampled at the rise
  task automatic bit_io(input logic b, output logic r);
    mosi = b;
    #100 sck = 1'b1;
    r = miso_wire;
    #100 sck = 1'b0;
  endtask : bit_io
  // Command byte, nw full words, nb bits of a partial word
  task automatic frame(input logic [7:0] cmd, input int nw, input logic [15:0] wd,
    input int nb);
    logic r;
    cs_n = 1'b0;
    for (int i = 7; i >= 0; i--) bit_io(cmd[i], r);
    for (int w = 0; w < nw; w++) begin
      for (int i = 15; i >= 0; i--) begin
        bit_io(wd[i], r);
        rx[w][i] = r;
      end
    end
    // Partial word, dropped by the device at deselect
    for (int i = 0; i < nb; i++) bit_io(1'b0, r);
    #100 cs_n = 1'b1;
    mosi = ~mosi;
    #200;
  endtask : frame
endmodule : sha_host
`default_nettype wire

// file: sha_mem.sv
// Simple dual-port word memory with a registered read port.
// Assumes write and read share one clock; read data follow one cycle late.
`timescale 1ns/1ps
`default_nettype none
module sha_mem #(
  parameter int AW = 6, // Address width
  parameter int DW = 16 // Word width
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [2**AW]; // Storage, left without reset to stay a RAM
  logic [DW-1:0] rdata_reg; // Registered read word

  // Write port
  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Read port, one cycle of latency
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= mem[raddr];
    end
  end

  assign rdata = rdata_reg;
endmodule : sha_mem
`default_nettype wire

// file: sha_pkg.sv
// Shared constants and types for the serial host pointer access block.
// Assumes a single system clock; all widths and codes except REG_PTR_LAST are used by sha_top.
`default_nettype none
package sha_pkg;
  // Register numbers reached by the fast-access commands
  localparam logic [5:0] REG_PTR_A = 6'h0b; // Address pointer A
  localparam logic [5:0] REG_PTR_LAST = 6'h0e; // Highest selectable pointer
  localparam logic [5:0] REG_PTR_VIEW = 6'h0f; // Enabled pointer view
  // Command bytes
  localparam logic [7:0] OP_SEL_PTR_A = 8'hd8; // Enable pointer A
  localparam logic [7:0] OP_PTR_INC = 8'hd0; // Add one to enabled pointer
  localparam logic [7:0] OP_PTR_READ = 8'h40; // Streaming read at pointer
  localparam logic [5:0] OP_SEL_HI = 6'h36; // Upper six bits of 0xd8..0xdb
  // Descriptor table of the first remote terminal
  localparam logic [15:0] TBL_BASE = 16'h0400; // Default table start
  localparam logic [15:0] TBL_END = 16'h05ff; // Default table end
  // Serial framing, bit index of the last bit in a unit
  localparam logic [3:0] CMD_LAST = 4'h7; // Command byte: 8 clocks
  localparam logic [3:0] WORD_LAST = 4'hf; // Data word: 16 clocks
  // Reset values
  localparam logic [15:0] PTR_RESET = 16'h0000; // Pointer registers
  localparam logic [1:0] SEL_RESET = 2'h0; // Pointer A enabled
  // Transaction states
  typedef enum logic [2:0] {
    ST_CMD, ST_FIRST, ST_LOAD, ST_ADV, ST_PRE, ST_STREAM, ST_WDATA, ST_IGNORE
  } sha_state_type;
endpackage : sha_pkg
`default_nettype wire

// file: sha_top.sv
// Serial slave command logic giving a host access to registers and RAM.
// Assumes an SPI master in mode 0 with SCK well below sys_clk / 8.
// Summary of operation
// - Each returned word's address comes from enabled pointer
// - Words keep streaming while select low and clocking
// - After each fetch, increment pointer and prefetch next
// - Inside descriptor table, stop before a Control Word
// - Held pointer repeats previous word, no prefetch
// - Descriptor table spans 0x0400 to 0x05FF by default
// - Command 0xD8 enables pointer register 0x000B
// - Command 0xD0 adds one to enabled pointer
// - Command 0x40 streams words from the pointer address
// - Command 0x8B plus word loads pointer register 11
// - Fast read: bits 7,6,1,0 zero, register in 5:2
// - Fast write: bits 7:6 are 10, register in 5:0
// - Every fourth table word is a Control Word
// - Command takes 8 clocks, each data word 16
`timescale 1ns/1ps
`default_nettype none
module sha_top
  import sha_pkg::*;
#(
  parameter int RAM_AW = 15, // RAM word address width
  parameter logic [15:0] TABLE_BASE = TBL_BASE, // Descriptor table start
  parameter logic [15:0] TABLE_END = TBL_END // Descriptor table end
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe_n,
  input wire logic eng_we,
  input wire logic [RAM_AW-1:0] eng_addr,
  input wire logic [15:0] eng_wdata,
  output logic [15:0] ptr_enabled
);
  // Two-flop synchronisers; stage one feeds only stage two
  logic [2:0] sck_s1_reg, sck_s2_reg; // {cs_n, mosi, sck} stages
  logic sck_d_reg; // Delayed copy of synchronised SCK for edges
  logic sck_rise, sck_fall, cs_idle, mosi_s;
  // Transaction state
  sha_state_type state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next; // Bit index within the current unit
  logic [15:0] rx_reg, rx_next; // Incoming shift register
  logic [15:0] tx_reg, tx_next; // Outgoing shift register
  logic [15:0] pre_reg, pre_next; // Prefetched next word
  logic [7:0] op_reg, op_next; // Command byte of this transaction
  logic miso_reg, miso_next; // Output bit, changes on falling SCK
  logic [15:0] ptr_reg [4]; // Pointer registers 11..14
  logic [15:0] ptr_next [4];
  logic [1:0] sel_reg, sel_next; // Which pointer is enabled
  // Memory ports
  logic [RAM_AW-1:0] ram_raddr;
  logic [15:0] ram_rdata, reg_rdata, reg_word;
  logic reg_we;
  // Decode helpers
  logic [7:0] byte_in; // Command byte completing on this edge
  logic [15:0] word_in; // Data word completing on this edge
  logic [15:0] nxt_addr; // Address after the enabled pointer
  logic cw_next; // Next address holds a Control Word
  logic is_fast_rd, is_fast_wr, cmd_done, wr_done, word_end;
  logic [3:0] ridx; // Fast-read register minus 11
  logic [5:0] widx; // Fast-write register minus 11

  // Synchronisers and edge finding on the sampled SCK
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sck_s1_reg <= 3'h4;
      sck_s2_reg <= 3'h4;
      sck_d_reg <= 1'b0;
    end else begin
      sck_s1_reg <= {spi_cs_n, spi_mosi, spi_sck};
      sck_s2_reg <= sck_s1_reg;
      sck_d_reg <= sck_s2_reg[0];
    end
  end
  assign cs_idle = sck_s2_reg[2];
  assign mosi_s = sck_s2_reg[1];
  assign sck_rise = sck_s2_reg[0] && !sck_d_reg && !cs_idle;
  assign sck_fall = !sck_s2_reg[0] && sck_d_reg && !cs_idle;

  // Decode of the arriving byte and of the enabled pointer
  assign byte_in = {rx_reg[6:0], mosi_s}; // MSB first
  assign word_in = {rx_reg[14:0], mosi_s};
  assign ptr_enabled = ptr_reg[sel_reg]; // Visible as register 15
  assign nxt_addr = ptr_enabled + 16'h0001;
  // Entries are four words long and open with a Control Word
  assign cw_next = (nxt_addr >= TABLE_BASE) && (nxt_addr <= TABLE_END)
                   && (nxt_addr[1:0] == TABLE_BASE[1:0]);
  assign is_fast_rd = (byte_in[7:6] == 2'h0) && (byte_in[1:0] == 2'h0);
  assign is_fast_wr = (byte_in[7:6] == 2'h2);
  assign cmd_done = (state_reg == ST_CMD) && sck_rise && (cnt_reg == CMD_LAST);
  assign word_end = sck_rise && (cnt_reg == WORD_LAST);
  assign wr_done = (state_reg == ST_WDATA) && word_end;
  assign ridx = op_reg[5:2] - REG_PTR_A[3:0];
  assign widx = op_reg[5:0] - REG_PTR_A;
  assign reg_we = wr_done && ((op_reg[5:0] < REG_PTR_A) || (op_reg[5:0] > REG_PTR_VIEW));

  // Registers 11..15 live in flops; the rest in the register memory
  always_comb begin
    if (op_reg[5:2] == REG_PTR_VIEW[3:0]) begin
      reg_word = ptr_enabled;
    end else if (op_reg[5:2] >= REG_PTR_A[3:0]) begin
      reg_word = ptr_reg[ridx[1:0]];
    end else begin
      reg_word = reg_rdata;
    end
  end

  // RAM read address: current pointer, or the one after for prefetch
  assign ram_raddr = (state_reg == ST_ADV) ? nxt_addr[RAM_AW-1:0]
                                           : ptr_enabled[RAM_AW-1:0];

  sha_mem #(.AW(RAM_AW), .DW(16)) u_ram (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .we(eng_we),
    .waddr(eng_addr),
    .wdata(eng_wdata),
    .raddr(ram_raddr),
    .rdata(ram_rdata)
  );

  sha_mem #(.AW(6), .DW(16)) u_regs (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .we(reg_we),
    .waddr(op_reg[5:0]),
    .wdata(word_in),
    .raddr({2'h0, op_reg[5:2]}),
    .rdata(reg_rdata)
  );

  // Next-state logic of the transaction
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    rx_next = rx_reg;
    tx_next = tx_reg;
    pre_next = pre_reg;
    op_next = op_reg;
    miso_next = miso_reg;
    sel_next = sel_reg;
    for (int i = 0; i < 4; i++) begin
      ptr_next[i] = ptr_reg[i];
    end
    if (sck_rise) begin
      rx_next = word_in; // MSB first
      cnt_next = cnt_reg + 4'h1;
    end
    // Output bit moves on falling SCK; fetch states overlap this edge
    if (sck_fall && (state_reg inside {ST_ADV, ST_PRE, ST_STREAM})) begin
      miso_next = tx_reg[15];
      tx_next = {tx_reg[14:0], 1'b0};
    end
    unique case (state_reg)
      ST_CMD: begin
        if (cmd_done) begin
          op_next = byte_in;
          cnt_next = 4'h0;
          if (is_fast_rd || (byte_in == OP_PTR_READ)) begin
            state_next = ST_FIRST;
          end else if (is_fast_wr) begin
            state_next = ST_WDATA;
          end else if (byte_in[7:2] == OP_SEL_HI) begin
            sel_next = byte_in[1:0]; // 0xd8 picks pointer A
            state_next = ST_IGNORE;
          end else if (byte_in == OP_PTR_INC) begin
            ptr_next[sel_reg] = nxt_addr;
            state_next = ST_IGNORE;
          end else begin
            state_next = ST_IGNORE; // Unsupported command: no effect
          end
        end
      end
      ST_FIRST: begin
        state_next = ST_LOAD; // Memories present the word next cycle
      end
      ST_LOAD: begin
        tx_next = (op_reg == OP_PTR_READ) ? ram_rdata : reg_word;
        pre_next = tx_next; // A held pointer repeats this word
        state_next = (op_reg == OP_PTR_READ) ? ST_ADV : ST_STREAM;
      end
      ST_ADV: begin
        if (cw_next) begin
          state_next = ST_STREAM; // Held: no increment, no prefetch
        end else begin
          ptr_next[sel_reg] = nxt_addr;
          state_next = ST_PRE;
        end
      end
      ST_PRE: begin
        pre_next = ram_rdata; // Prefetch even if never read
        state_next = ST_STREAM;
      end
      ST_STREAM: begin
        if (word_end) begin
          tx_next = pre_next; // Prefetched word; a repeat of the last word when held or on a fast read
          cnt_next = 4'h0;
          if (op_reg == OP_PTR_READ) begin
            state_next = ST_ADV;
          end
        end
      end
      ST_WDATA: begin
        if (wr_done) begin
          cnt_next = 4'h0;
          if (op_reg[5:0] == REG_PTR_VIEW) begin
            ptr_next[sel_reg] = word_in;
          end else if (op_reg[5:0] >= REG_PTR_A) begin
            ptr_next[widx[1:0]] = word_in; // 0x8b loads pointer A
          end
        end
      end
      ST_IGNORE: begin
        cnt_next = 4'h0; // Clocks after a dataless command do nothing
      end
    endcase
    // Select high ends everything; an unsent prefetch is dropped
    if (cs_idle) begin
      state_next = ST_CMD;
      cnt_next = 4'h0;
    end
  end

  // State registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_CMD;
      cnt_reg <= 4'h0;
      rx_reg <= 16'h0000;
      tx_reg <= 16'h0000;
      pre_reg <= 16'h0000;
      op_reg <= 8'h00;
      miso_reg <= 1'b0;
      sel_reg <= SEL_RESET;
      for (int i = 0; i < 4; i++) begin
        ptr_reg[i] <= PTR_RESET;
      end
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      rx_reg <= rx_next;
      tx_reg <= tx_next;
      pre_reg <= pre_next;
      op_reg <= op_next;
      miso_reg <= miso_next;
      sel_reg <= sel_next;
      for (int i = 0; i < 4; i++) begin
        ptr_reg[i] <= ptr_next[i];
      end
    end
  end

  // Output drives only while selected
  assign spi_miso = miso_reg;
  assign spi_miso_oe_n = cs_idle;

  // Checks
  sequence seq_fetch;
    (state_reg == ST_FIRST) ##1 (state_reg == ST_LOAD);
  endsequence
  chk_ptr_advance: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_reg == ST_ADV) && !cw_next && !cs_idle |=> ptr_enabled == $past(ptr_enabled) + 16'h0001)
    else $error("pointer did not advance after fetch");
  chk_cw_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_reg == ST_ADV) && cw_next |=> $stable(ptr_enabled) && $stable(pre_reg))
    else $error("pointer moved before a control word");
  chk_select_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    cmd_done && (byte_in == OP_SEL_PTR_A) && !cs_idle |=> sel_reg == 2'h0)
    else $error("pointer A not enabled");
  chk_incr_cmd: assert property (@(posedge sys_clk) disable iff (!rstn)
    cmd_done && (byte_in == OP_PTR_INC) && !cs_idle
    |=> ptr_enabled == $past(ptr_enabled) + 16'h0001)
    else $error("increment command missed");
  // Pointer read must fetch, load and then move on to the advance step
  chk_read_start: assert property (@(posedge sys_clk) disable iff (!rstn || cs_idle)
    cmd_done && (byte_in == OP_PTR_READ) |=> seq_fetch ##1 (state_reg == ST_ADV))
    else $error("read start malformed");
  chk_fetch_seq: assert property (@(posedge sys_clk) disable iff (!rstn || cs_idle)
    cmd_done && is_fast_rd |=> seq_fetch)
    else $error("fast read did not fetch");
  chk_ptr_load: assert property (@(posedge sys_clk) disable iff (!rstn)
    wr_done && (op_reg[5:0] == REG_PTR_A) && !cs_idle |=> ptr_reg[0] == $past(word_in))
    else $error("pointer A load failed");
  chk_word_reload: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_reg == ST_STREAM) && word_end && !cs_idle |=> tx_reg == $past(pre_reg))
    else $error("next word not loaded");
  chk_cs_abort: assert property (@(posedge sys_clk) disable iff (!rstn)
    cs_idle |=> (state_reg == ST_CMD) && (cnt_reg == 4'h0))
    else $error("select high did not end transaction");
endmodule : sha_top
`default_nettype wire

// file: sha_top_tb.sv
// Bench for sha_top: host frames through sha_host, replies judged per scenario.
// Assumes RAM contents are preloaded through the engine write port.
`timescale 1ns/1ps
`default_nettype none
module sha_top_tb;
  import sha_pkg::*;
  logic sys_clk; // 40 MHz system clock
  logic rstn; // Active-low reset
  logic spi_sck, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe_n; // Serial link
  logic eng_we; // Engine RAM write strobe
  logic [14:0] eng_addr; // Engine RAM address
  logic [15:0] eng_wdata; // Engine RAM data
  logic [15:0] ptr_enabled; // Enabled pointer view
  int error_cnt = 0;
  int compares = 0;
  sha_top uut (.sys_clk, .rstn, .spi_sck, .spi_cs_n, .spi_mosi, .spi_miso,
    .spi_miso_oe_n, .eng_we, .eng_addr, .eng_wdata, .ptr_enabled);
  sha_host host (.sck(spi_sck), .cs_n(spi_cs_n), .mosi(spi_mosi), .miso(spi_miso),
    .miso_oe_n(spi_miso_oe_n));
  // Clock toggles every half period
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Distinct word per address, so a repeated or skipped word shows
  function automatic logic [15:0] pat(input logic [15:0] a);
    return a ^ 16'h5a00;
  endfunction : pat
  // Word compare with case inequality
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk16
  // Preload n words from a0; strobe held high across the burst
  task automatic fill(input logic [15:0] a0, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge sys_clk);
      eng_we = 1'b1;
      eng_addr = a0[14:0] + 15'(i);
      eng_wdata = pat(a0 + 16'(i));
    end
    @(negedge sys_clk);
    eng_we = 1'b0;
  endtask : fill
  // Pointer A load, used to set where a pointer read starts
  task automatic load(input logic [15:0] v);
    host.frame(8'h8b, 1, v, 0);
  endtask : load
  // Reset state of the outputs
  task automatic test_reset();
    chk16(ptr_enabled, PTR_RESET);
    chk16({15'h0000, spi_miso_oe_n}, 16'h0001);
    host.frame(8'h2c, 1, 16'h0000, 0);
    chk16(host.rx[0], PTR_RESET);
    $display("test_reset done");
  endtask : test_reset
  // Fast writes and reads of every pointer register, plus selection
  task automatic test_regs();
    logic [15:0] v;
    for (int k = 0; k < 4; k++) begin
      v = {4'h1, 4'(k), 8'h55};
      host.frame(8'h8b + 8'(k), 1, v, 0);
      host.frame(OP_SEL_PTR_A + 8'(k), 0, 16'h0000, 0);
      chk16(ptr_enabled, v);
      host.frame(8'h2c + 8'(4 * k), 2, 16'h0000, 0);
      chk16(host.rx[0], v);
      chk16(host.rx[1], v);
    end
    host.frame(8'h81, 1, 16'h1234, 0);
    host.frame(8'h04, 1, 16'h0000, 0);
    chk16(host.rx[0], 16'h1234);
    host.frame(OP_SEL_PTR_A, 0, 16'h0000, 0);
    chk16(ptr_enabled, 16'h1055);
    host.frame(8'h8f, 1, 16'h0200, 0);
    host.frame(8'h3c, 1, 16'h0000, 0);
    chk16(host.rx[0], 16'h0200);
    chk16(ptr_enabled, 16'h0200);
    // Bit 6 set: not a fast write, so the data word must change nothing
    host.frame(8'hc0, 1, 16'hffff, 0);
    chk16(ptr_enabled, 16'h0200);
    $display("test_regs done");
  endtask : test_regs
  // Streaming outside the table, then a frame cut in mid-word
  task automatic test_stream();
    fill(16'h0100, 8);
    load(16'h0100);
    host.frame(OP_PTR_READ, 6, 16'h0000, 0);
    for (int i = 0; i < 6; i++) chk16(host.rx[i], pat(16'h0100 + 16'(i)));
    chk16(ptr_enabled, 16'h0107);
    load(16'h0100);
    host.frame(OP_PTR_READ, 1, 16'h0000, 8);
    chk16(host.rx[0], pat(16'h0100));
    chk16(ptr_enabled, 16'h0102);
    host.frame(OP_PTR_READ, 1, 16'h0000, 0);
    chk16(host.rx[0], pat(16'h0102));
    $display("test_stream done");
  endtask : test_stream
  // Table read that sticks, the host workaround loop, and the table end
  task automatic test_table();
    logic [15:0] a;
    fill(16'h03ff, 13);
    load(TBL_BASE);
    host.frame(OP_PTR_READ, 6, 16'h0000, 0);
    for (int i = 0; i < 6; i++) begin
      a = (i < 3) ? TBL_BASE + 16'(i) : 16'h0403;
      chk16(host.rx[i], pat(a));
    end
    chk16(ptr_enabled, 16'h0403);
    // Start one below the base, then increment and read four words
    load(TBL_BASE - 16'h0001);
    for (int r = 0; r < 3; r++) begin
      host.frame(OP_PTR_INC, 0, 16'h0000, 0);
      chk16(ptr_enabled, TBL_BASE + 16'(4 * r));
      host.frame(OP_PTR_READ, 4, 16'h0000, 0);
      for (int i = 0; i < 4; i++) chk16(host.rx[i], pat(TBL_BASE + 16'(4 * r + i)));
    end
    // Last entry: the word after the end is no Control Word
    fill(16'h05fb, 7);
    load(16'h05fb);
    host.frame(OP_PTR_INC, 0, 16'h0000, 0);
    host.frame(OP_PTR_READ, 4, 16'h0000, 0);
    for (int i = 0; i < 4; i++) chk16(host.rx[i], pat(16'h05fc + 16'(i)));
    chk16(ptr_enabled, 16'h0601);
    $display("test_table done");
  endtask : test_table
  // Counts, verdict and end of run
  task automatic summarize();
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize
  // Hang guard, far above the normal run length
  initial begin
    repeat (100000) @(posedge sys_clk);
    error_cnt++;
    summarize();
  end
  // Main sequence: reset for four cycles, then the scenarios
  initial begin
    rstn = 1'b0;
    eng_we = 1'b0;
    eng_addr = 15'h0000;
    eng_wdata = 16'h0000;
    repeat (4) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (3) @(negedge sys_clk);
    test_reset();
    test_regs();
    test_stream();
    test_table();
    summarize();
  end
endmodule : sha_top_tb
`default_nettype wire
